//--- hdl/icm_pkg.sv
`default_nettype none
package icm_pkg;
	// ==============================================
	// Widths
	localparam int NREF = 3;
	localparam int NGPIO = 3;
	localparam int CW = 24;
	localparam int PCT_W = 5;
	localparam int PPM_W = 9;
	localparam int DIV_W = 4;
	localparam int FN_W = 4;
	localparam int LSS_W = 3;
	// ==============================================
	// Global register offsets
	localparam logic [7:0] OFF_MCR = 8'h00;
	localparam logic [7:0] OFF_IEN = 8'h04;
	localparam logic [7:0] OFF_GPIO = 8'h08;
	localparam logic [7:0] OFF_MQC = 8'h0c;
	localparam logic [7:0] OFF_VAL = 8'h10;
	localparam logic [7:0] OFF_LOCK_TIMEOUT_FLAG = 8'h14;
	localparam logic [7:0] OFF_ACTWIN = 8'h18;
	localparam logic [7:0] OFF_FRQWIN = 8'h1c;
	localparam logic [7:0] OFF_QUAL = 8'h20;
	// Per input groups: upper nibble is the group, bits 3:2 the input
	localparam logic [3:0] GRP_ISR = 4'h3;
	localparam logic [3:0] GRP_ICR = 4'h4;
	localparam logic [3:0] GRP_MON = 4'h5;
	localparam logic [3:0] GRP_EXP = 4'h6;
	// ==============================================
	// Field positions
	localparam int MCR_SEL = 0;
	localparam int MCR_ROSC = 1;
	localparam int MCR_APLL = 2;
	localparam int VAL_LATCH_LSB = 8;
	localparam int ISR_ACT = 0;
	localparam int ISR_PCT = 1;
	localparam int ISR_PPM = 2;
	localparam int ISR_LOS = 3;
	localparam int ISR_PASS = 4;
	localparam int ISR_USE = 5;
	localparam int ISR_LOCK_TIMEOUT_FLAG = 6;
	localparam int ICR_EDGE = 0;
	localparam int ICR_DIV_LSB = 4;
	localparam int MON_ACT = 0;
	localparam int MON_PCT = 1;
	localparam int MON_PPM = 2;
	localparam int MON_LSS_LSB = 4;
	localparam int MON_PCT_LSB = 8;
	localparam int MON_PPM_LSB = 16;
	// ==============================================
	// Codes and scales
	localparam logic [FN_W-1:0] GPF_PLAIN = 4'h0;
	localparam logic [FN_W-1:0] GPF_INV = 4'h1;
	localparam logic [LSS_W-1:0] LSS_GPIO1 = 3'h2;
	localparam logic [47:0] PCT_SCALE = 48'h0000_0000_0064;
	localparam logic [47:0] PPM_SCALE = 48'h0000_000f_4240;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==============================================
	// Values after reset
	localparam logic [2:0] RST_MCR = 3'h0;
	localparam logic [2:0] RST_IEN = 3'h0;
	localparam logic [11:0] RST_GPIO = 12'h000;
	localparam logic [2:0] RST_MQC = 3'h7;
	localparam logic [CW-1:0] RST_LOCK_TIMEOUT_FLAG = 24'h000000;
	localparam logic [CW-1:0] RST_ACTWIN = 24'h000400;
	localparam logic [CW-1:0] RST_FRQWIN = 24'h010000;
	localparam logic [CW-1:0] RST_QUAL = 24'h000000;
	localparam logic [7:0] RST_ICR = 8'h00;
	localparam logic [31:0] RST_MON = 32'h0064_0a07;
	localparam logic [CW-1:0] RST_EXP = 24'h000000;
endpackage : icm_pkg
`default_nettype wire

//--- hdl/icm_sync.sv
`default_nettype none
// ==============================================
// Two-stage synchroniser for pin levels
module icm_sync #(parameter int W = 1) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;

	// First stage feeds only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			q <= '0;
		end else begin
			s1_q <= d;
			q <= s1_q;
		end
	end
endmodule : icm_sync
`default_nettype wire

//--- hdl/icm_mon.sv
`default_nettype none
// ==============================================
// Monitor chain and qualification timer of one input
module icm_mon import icm_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Reference events and control
	input wire logic edge_p,
	input wire logic en,
	input wire logic act_on,
	input wire logic pct_on,
	input wire logic ppm_on,
	input wire logic signal_gone_flag,
	input wire logic [CW-1:0] act_win,
	input wire logic [CW-1:0] frq_win,
	input wire logic [CW-1:0] expect_cnt,
	input wire logic [CW-1:0] qual_time,
	input wire logic [PCT_W-1:0] pct_thr,
	input wire logic [PPM_W-1:0] ppm_thr,
	// Status
	output logic act_ok,
	output logic pct_ok,
	output logic ppm_ok,
	output logic pass,
	output logic usable
);
	logic [CW-1:0] aw_q, fw_q, fc_q, fc_n, qc_q, diff;
	logic seen_q, act_raw_q, pct_raw_q, ppm_raw_q, act_good, a_end, f_end;
	logic [47:0] d_pct, d_ppm, e_pct, e_ppm;

	// Activity flag only counts if no signal loss upstream
	assign act_good = en & ~signal_gone_flag & (~act_on | act_raw_q);
	assign a_end = (aw_q >= act_win);
	assign f_end = (fw_q >= frq_win);
	assign fc_n = fc_q + {23'h0, edge_p}; // Edge in the closing cycle still counts
	assign diff = (fc_n > expect_cnt) ? fc_n - expect_cnt : expect_cnt - fc_n;
	assign d_pct = {24'h0, diff} * PCT_SCALE;
	assign d_ppm = {24'h0, diff} * PPM_SCALE;
	assign e_pct = {24'h0, expect_cnt} * {43'h0, pct_thr};
	assign e_ppm = {24'h0, expect_cnt} * {39'h0, ppm_thr};
	// Disabled monitors always report passing
	assign act_ok = ~act_on | (act_raw_q & ~signal_gone_flag);
	assign pct_ok = ~pct_on | (pct_raw_q & act_good);
	assign ppm_ok = ~ppm_on | (ppm_raw_q & act_good);
	assign pass = en & ~signal_gone_flag & act_ok & pct_ok & ppm_ok;
	assign usable = pass & (qc_q >= qual_time);

	// Activity window: any edge in the interval counts as alive
	always_ff @(posedge aclk) begin
		if (!aresetn || !en) begin
			aw_q <= '0;
			seen_q <= 1'b0;
			act_raw_q <= 1'b0;
		end else if (a_end) begin
			aw_q <= '0;
			seen_q <= 1'b0;
			act_raw_q <= seen_q | edge_p;
		end else begin
			aw_q <= aw_q + 24'h1;
			seen_q <= seen_q | edge_p;
		end
	end

	// Frequency window restarts whenever activity has not passed
	always_ff @(posedge aclk) begin
		if (!aresetn || !act_good) begin
			fw_q <= '0;
			fc_q <= '0;
			pct_raw_q <= 1'b0;
			ppm_raw_q <= 1'b0;
		end else if (f_end) begin
			fw_q <= '0;
			fc_q <= '0;
			pct_raw_q <= (d_pct <= e_pct);
			ppm_raw_q <= (d_ppm <= e_ppm);
		end else begin
			fw_q <= fw_q + 24'h1;
			fc_q <= fc_n;
		end
	end

	// Qualification timer restarts on any failure
	always_ff @(posedge aclk) begin
		if (!aresetn || !pass) begin
			qc_q <= '0;
		end else if (qc_q < qual_time) begin
			qc_q <= qc_q + 24'h1;
		end
	end
endmodule : icm_mon
`default_nettype wire

//--- hdl/icm_top.sv
`default_nettype none
module icm_top import icm_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Reference and GPIO pins
	input wire logic [NREF-1:0] ref_pin,
	input wire logic [NGPIO-1:0] gpio_pin,
	// DPLL side
	input wire logic dpll_locked,
	input wire logic [1:0] selected_ref,
	output logic [NREF-1:0] ref_edge,
	output logic [NREF-1:0] ref_valid,
	output logic [NREF-1:0] ref_selectable,
	// Clock sourcing
	output logic master_clk_from_ext,
	output logic reg_clk_from_ring,
	output logic ring_osc_en
);
	// ==============================================
	// Register state
	logic [2:0] mcr_q, ien_q, mqc_q, latch_q, valid_prev_q;
	logic [11:0] gpio_q;
	logic [CW-1:0] lock_timeout_flag_per_q, actwin_q, frqwin_q, qual_q, lk_cnt_q;
	logic [7:0] icr_q [NREF];
	logic [31:0] mon_q [NREF];
	logic [CW-1:0] exp_q [NREF];
	logic [NREF-1:0] lock_timeout_flag_q;
	logic [1:0] sel_prev_q;

	// AXI channel state
	logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;

	// Monitor results
	logic [NREF-1:0] act_ok, pct_ok, ppm_ok, pass, usable, signal_gone_flag, valid_now;
	logic [NREF-1:0] ref_s;
	logic [NGPIO-1:0] gpio_s, gp_lvl;
	logic [31:0] isr_w [NREF];

	// ==============================================
	// Clock sourcing
	// The ring stays on while it still clocks the registers, so a stray
	// disable cannot stop the only clock software has.
	assign reg_clk_from_ring = ~master_clk_from_ext;
	assign master_clk_from_ext = mcr_q[MCR_SEL] & ~mcr_q[MCR_APLL];
	assign ring_osc_en = ~mcr_q[MCR_ROSC] | mcr_q[MCR_APLL]
		| reg_clk_from_ring;

	// ==============================================
	// Pin synchronisers
	icm_sync #(.W(NREF + NGPIO)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({gpio_pin, ref_pin}),
		.q({gpio_s, ref_s})
	);

	// GPIO input function: plain, inverted, or not an input
	genvar gg;
	generate
		for (gg = 0; gg < NGPIO; gg++) begin : g_gpio
			logic [FN_W-1:0] fn;
			assign fn = gpio_q[gg*FN_W +: FN_W];
			assign gp_lvl[gg] = (fn == GPF_INV) ? ~gpio_s[gg]
				: (fn == GPF_PLAIN) ? gpio_s[gg] : 1'b0;
		end
	endgenerate

	// ==============================================
	// Per input: edge select, divider, loss routing, monitors
	genvar gi;
	generate
		for (gi = 0; gi < NREF; gi++) begin : g_ref
			logic prev_q, dedge_q, edge_raw, los_hit;
			logic [DIV_W-1:0] dcnt_q, div_n;
			logic [LSS_W-1:0] lss, lidx;
			assign div_n = icr_q[gi][ICR_DIV_LSB +: DIV_W];
			// Falling edge when the polarity bit is set
			assign edge_raw = ien_q[gi] & (icr_q[gi][ICR_EDGE]
				? (prev_q & ~ref_s[gi]) : (~prev_q & ref_s[gi]));
			assign lss = mon_q[gi][MON_LSS_LSB +: LSS_W];
			assign lidx = lss - LSS_GPIO1;
			assign los_hit = (lss >= LSS_GPIO1) && (lidx < 3'(NGPIO));
			assign signal_gone_flag[gi] = los_hit & gp_lvl[lidx[1:0]];
			assign ref_edge[gi] = dedge_q;

			// Divider emits one event per div_n+1 selected edges
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					prev_q <= 1'b0;
					dcnt_q <= '0;
					dedge_q <= 1'b0;
				end else begin
					prev_q <= ref_s[gi];
					dedge_q <= edge_raw & (dcnt_q == div_n);
					if (!ien_q[gi]) begin
						dcnt_q <= '0;
					end else if (edge_raw) begin
						dcnt_q <= (dcnt_q >= div_n) ? '0 : dcnt_q + 4'h1;
					end
				end
			end

			icm_mon u_mon (
				.aclk(aclk),
				.aresetn(aresetn),
				.edge_p(dedge_q),
				.en(ien_q[gi]),
				.act_on(mon_q[gi][MON_ACT]),
				.pct_on(mon_q[gi][MON_PCT]),
				.ppm_on(mon_q[gi][MON_PPM]),
				.signal_gone_flag(signal_gone_flag[gi]),
				.act_win(actwin_q),
				.frq_win(frqwin_q),
				.expect_cnt(exp_q[gi]),
				.qual_time(qual_q),
				.pct_thr(mon_q[gi][MON_PCT_LSB +: PCT_W]),
				.ppm_thr(mon_q[gi][MON_PPM_LSB +: PPM_W]),
				.act_ok(act_ok[gi]),
				.pct_ok(pct_ok[gi]),
				.ppm_ok(ppm_ok[gi]),
				.pass(pass[gi]),
				.usable(usable[gi])
			);

			assign isr_w[gi] = {25'h0, lock_timeout_flag_q[gi], usable[gi], pass[gi],
				signal_gone_flag[gi], ppm_ok[gi], pct_ok[gi], act_ok[gi]};
		end
	endgenerate

	// ==============================================
	// Validity towards the selector
	assign valid_now = usable & ~lock_timeout_flag_q;
	assign ref_valid = valid_now;
	assign ref_selectable = valid_now & mqc_q;

	// ==============================================
	// Lock timeout on the selected reference
	logic sel_ok, lk_hit;
	assign sel_ok = (selected_ref != 2'h3) && (selected_ref == sel_prev_q);
	assign lk_hit = sel_ok & ~dpll_locked & (lock_timeout_flag_per_q != '0)
		& (lk_cnt_q == lock_timeout_flag_per_q);

	// Counter restarts on lock or on any change of selection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lk_cnt_q <= '0;
			sel_prev_q <= 2'h3;
		end else begin
			sel_prev_q <= selected_ref;
			if (!sel_ok || dpll_locked) begin
				lk_cnt_q <= '0;
			end else if (lk_cnt_q != lock_timeout_flag_per_q) begin
				lk_cnt_q <= lk_cnt_q + 24'h1;
			end
		end
	end

	// ==============================================
	// AXI4-Lite handshakes
	assign awready = ~aw_hold_q;
	assign wready = ~w_hold_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = ~rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// Write decode on the held address
	logic do_wr, wg_ok, wr_hit;
	logic [7:0] wa;
	logic [1:0] wi;
	logic [31:0] wbe;
	logic we_mcr, we_ien, we_gpio, we_mqc, we_val, we_lock_timeout_flag;
	logic we_actw, we_frqw, we_qual, we_isr, we_icr, we_mon, we_exp;
	assign do_wr = aw_hold_q & w_hold_q & ~bvalid_q;
	assign wa = {awaddr_q[7:2], 2'h0};
	assign wi = wa[3:2];
	assign wg_ok = (wi != 2'h3);
	assign wbe = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	// Lane-masked new data and keep mask, sliced per register width
	logic [31:0] wn, wk;
	assign wn = wdata_q & wbe;
	assign wk = ~wbe;
	assign we_mcr = do_wr & (wa == OFF_MCR);
	assign we_ien = do_wr & (wa == OFF_IEN);
	assign we_gpio = do_wr & (wa == OFF_GPIO);
	assign we_mqc = do_wr & (wa == OFF_MQC);
	assign we_val = do_wr & (wa == OFF_VAL);
	assign we_lock_timeout_flag = do_wr & (wa == OFF_LOCK_TIMEOUT_FLAG);
	assign we_actw = do_wr & (wa == OFF_ACTWIN);
	assign we_frqw = do_wr & (wa == OFF_FRQWIN);
	assign we_qual = do_wr & (wa == OFF_QUAL);
	assign we_isr = do_wr & wg_ok & (wa[7:4] == GRP_ISR);
	assign we_icr = do_wr & wg_ok & (wa[7:4] == GRP_ICR);
	assign we_mon = do_wr & wg_ok & (wa[7:4] == GRP_MON);
	assign we_exp = do_wr & wg_ok & (wa[7:4] == GRP_EXP);
	assign wr_hit = we_mcr | we_ien | we_gpio | we_mqc | we_val | we_lock_timeout_flag
		| we_actw | we_frqw | we_qual | we_isr | we_icr | we_mon | we_exp;

	// Byte-lane merge of new data into a stored word
	function automatic logic [31:0] lane(input logic [31:0] o,
		input logic [31:0] n, input logic [31:0] m);
		lane = (o & ~m) | (n & m);
	endfunction : lane

	// Address and data are taken in either order and held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (awvalid && !aw_hold_q) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= awaddr;
			end
			if (wvalid && !w_hold_q) begin
				w_hold_q <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (do_wr) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read select on the incoming address
	logic [7:0] ra;
	logic [1:0] ri;
	logic [31:0] rd_d;
	logic rd_err;
	assign ra = {araddr[7:2], 2'h0};
	assign ri = ra[3:2];
	always_comb begin
		rd_d = 32'h0;
		rd_err = 1'b0;
		case (ra)
			OFF_MCR: rd_d = {29'h0, mcr_q};
			OFF_IEN: rd_d = {29'h0, ien_q};
			OFF_GPIO: rd_d = {20'h0, gpio_q};
			OFF_MQC: rd_d = {29'h0, mqc_q};
			OFF_VAL: rd_d = {21'h0, latch_q, 5'h0, valid_now};
			OFF_LOCK_TIMEOUT_FLAG: rd_d = {8'h0, lock_timeout_flag_per_q};
			OFF_ACTWIN: rd_d = {8'h0, actwin_q};
			OFF_FRQWIN: rd_d = {8'h0, frqwin_q};
			OFF_QUAL: rd_d = {8'h0, qual_q};
			default: begin
				if (ri == 2'h3) begin
					rd_err = 1'b1;
				end else begin
					case (ra[7:4])
						GRP_ISR: rd_d = isr_w[ri];
						GRP_ICR: rd_d = {24'h0, icr_q[ri]};
						GRP_MON: rd_d = mon_q[ri];
						GRP_EXP: rd_d = {8'h0, exp_q[ri]};
						default: rd_err = 1'b1;
					endcase
				end
			end
		endcase
	end

	// Read answer is registered on the same edge that takes the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_d;
			rresp_q <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ==============================================
	// Global control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mcr_q <= RST_MCR;
			ien_q <= RST_IEN;
			gpio_q <= RST_GPIO;
			mqc_q <= RST_MQC;
			lock_timeout_flag_per_q <= RST_LOCK_TIMEOUT_FLAG;
			actwin_q <= RST_ACTWIN;
			frqwin_q <= RST_FRQWIN;
			qual_q <= RST_QUAL;
		end else begin
			if (we_mcr) mcr_q <= (mcr_q & wk[2:0]) | wn[2:0];
			if (we_ien) ien_q <= (ien_q & wk[2:0]) | wn[2:0];
			if (we_gpio) gpio_q <= (gpio_q & wk[11:0]) | wn[11:0];
			if (we_mqc) mqc_q <= (mqc_q & wk[2:0]) | wn[2:0];
			if (we_lock_timeout_flag) lock_timeout_flag_per_q <= (lock_timeout_flag_per_q & wk[23:0]) | wn[23:0];
			if (we_actw) actwin_q <= (actwin_q & wk[23:0]) | wn[23:0];
			if (we_frqw) frqwin_q <= (frqwin_q & wk[23:0]) | wn[23:0];
			if (we_qual) qual_q <= (qual_q & wk[23:0]) | wn[23:0];
		end
	end

	// ==============================================
	// Per input registers and sticky flags
	// Hardware set beats a software clear in the same cycle.
	logic [NREF-1:0] val_clr, lk_clr, lk_set;
	assign val_clr = (we_val & wstrb_q[1]) ? wdata_q[VAL_LATCH_LSB +: NREF] : '0;
	always_comb begin
		lk_clr = '0;
		lk_set = '0;
		for (int k = 0; k < NREF; k++) begin
			lk_clr[k] = we_isr & (wi == 2'(k)) & wstrb_q[0] & wdata_q[ISR_LOCK_TIMEOUT_FLAG];
			lk_set[k] = lk_hit & (selected_ref == 2'(k));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_q <= '0;
			valid_prev_q <= '0;
			lock_timeout_flag_q <= '0;
			for (int k = 0; k < NREF; k++) begin
				icr_q[k] <= RST_ICR;
				mon_q[k] <= RST_MON;
				exp_q[k] <= RST_EXP;
			end
		end else begin
			valid_prev_q <= valid_now;
			latch_q <= (latch_q & ~val_clr) | (valid_now ^ valid_prev_q);
			lock_timeout_flag_q <= (lock_timeout_flag_q & ~lk_clr) | lk_set;
			for (int k = 0; k < NREF; k++) begin
				if (we_icr && wi == 2'(k))
					icr_q[k] <= (icr_q[k] & wk[7:0]) | wn[7:0];
				if (we_mon && wi == 2'(k))
					mon_q[k] <= lane(mon_q[k], wdata_q, wbe);
				if (we_exp && wi == 2'(k))
					exp_q[k] <= (exp_q[k] & wk[23:0]) | wn[23:0];
			end
		end
	end
endmodule : icm_top
`default_nettype wire

//--- dv/icm_ref_model.sv
`default_nettype none
// ==============================================
// Reference source, period of 2*half aclk cycles
module icm_ref_model (
	// Clock
	input wire logic aclk,
	// Control
	input wire logic run,
	input wire logic [7:0] half,
	// Reference pin
	output logic ref_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q = 8'h00;
	logic ref_q = 1'b0;
	// Pin rests low between runs, so no stray edge reaches the monitors
	always @(posedge aclk) begin
		if (!run) begin
			cnt_q <= 8'h00;
			ref_q <= 1'b0;
		end else if (cnt_q + 8'h01 >= half) begin
			cnt_q <= 8'h00;
			ref_q <= ~ref_q;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
	assign ref_o = ref_q;
endmodule : icm_ref_model
`default_nettype wire

//--- dv/icm_checker.sv
`default_nettype none
// ==============================================
// Port checks of the monitor block
module icm_checker import icm_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic rvalid,
	// Reference and clock sourcing
	input wire logic [NREF-1:0] ref_pin,
	input wire logic [NREF-1:0] ref_edge,
	input wire logic [NREF-1:0] ref_valid,
	input wire logic [NREF-1:0] ref_selectable,
	input wire logic master_clk_from_ext,
	input wire logic reg_clk_from_ring,
	input wire logic ring_osc_en
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Steps that start a response, and a quiet reference pin
	sequence s_wr;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_quiet;
		$stable(ref_pin[0]) [*6];
	endsequence
	property p_start;
		$rose(aresetn) |-> reg_clk_from_ring && !master_clk_from_ext && ref_valid == 3'h0;
	endproperty
	a_start: assert property (p_start) else $error("bad start-up state");
	property p_pick;
		reg_clk_from_ring != master_clk_from_ext;
	endproperty
	a_pick: assert property (p_pick) else $error("clock source clash");
	property p_ring_on;
		reg_clk_from_ring |-> ring_osc_en;
	endproperty
	a_ring_on: assert property (p_ring_on) else $error("ring off while in use");
	property p_ring_off;
		!ring_osc_en |-> master_clk_from_ext;
	endproperty
	a_ring_off: assert property (p_ring_off) else $error("ring off too early");
	property p_excl;
		(ref_selectable & ~ref_valid) == 3'h0;
	endproperty
	a_excl: assert property (p_excl) else $error("invalid input selectable");
	property p_pulse;
		ref_edge[0] |=> !ref_edge[0];
	endproperty
	a_pulse: assert property (p_pulse) else $error("edge pulse too long");
	property p_idle;
		s_quiet |-> !ref_edge[0];
	endproperty
	a_idle: assert property (p_idle) else $error("edge from idle pin");
	property p_wr;
		s_wr |=> ##1 bvalid;
	endproperty
	a_wr: assert property (p_wr) else $error("write response late");
	property p_rd;
		arvalid && !rvalid |=> rvalid;
	endproperty
	a_rd: assert property (p_rd) else $error("read response late");
endmodule : icm_checker
bind icm_top icm_checker chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
	.rvalid(rvalid), .ref_pin(ref_pin), .ref_edge(ref_edge), .ref_valid(ref_valid),
	.ref_selectable(ref_selectable), .master_clk_from_ext(master_clk_from_ext),
	.reg_clk_from_ring(reg_clk_from_ring), .ring_osc_en(ring_osc_en));
`default_nettype wire

//--- dv/test_input_clock_monitor_validation.sv
`default_nettype none
// ==============================================
// Bench of the input clock monitor
module test_input_clock_monitor_validation import icm_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} icm_row_t;
	// Design pins
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [NGPIO-1:0] gpio_pin = 3'h7;
	logic dpll_locked = 1'b1;
	logic [1:0] selected_ref = 2'h3;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	wire logic [NREF-1:0] ref_pin;
	logic [NREF-1:0] ref_edge, ref_valid, ref_selectable;
	logic master_clk_from_ext, reg_clk_from_ring, ring_osc_en;
	// Partner control, tallies and tables
	logic [NREF-1:0] run = 3'h0;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	int edges = 0;
	int e0;
	logic [7:0] icr [4] = '{8'h00, 8'h01, 8'h11, 8'h31};
	logic [7:0] mon [4] = '{8'h21, 8'h22, 8'h24, 8'h20};
	logic [7:0] isr [4] = '{8'h06, 8'h05, 8'h03, 8'h37};
	icm_row_t rows [14] = '{'{8'h00, 32'h0, 2'h0}, '{8'h04, 32'h0, 2'h0},
		'{8'h08, 32'h0, 2'h0}, '{8'h0c, 32'h7, 2'h0}, '{8'h10, 32'h0, 2'h0},
		'{8'h14, 32'h0, 2'h0}, '{8'h18, 32'h400, 2'h0}, '{8'h1c, 32'h10000, 2'h0},
		'{8'h20, 32'h0, 2'h0}, '{8'h38, 32'h0, 2'h0}, '{8'h44, 32'h0, 2'h0},
		'{8'h54, 32'h0064_0a07, 2'h0}, '{8'h68, 32'h0, 2'h0}, '{8'hf0, 32'h0, RESP_SLVERR}};
	// Block and reference sources
	icm_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ref_pin(ref_pin), .gpio_pin(gpio_pin), .dpll_locked(dpll_locked),
		.selected_ref(selected_ref), .ref_edge(ref_edge), .ref_valid(ref_valid),
		.ref_selectable(ref_selectable), .master_clk_from_ext(master_clk_from_ext),
		.reg_clk_from_ring(reg_clk_from_ring), .ring_osc_en(ring_osc_en));
	icm_ref_model src [NREF-1:0] (.aclk(aclk), .run(run), .half(8'h04), .ref_o(ref_pin));
	// Clock, edge tally and hang guard
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		edges <= edges + 32'(ref_edge[0]);
		if (cycles == 30000) begin
			mismatches = mismatches + 1;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk
	// Address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		chk("bresp", 32'(er), 32'(bresp));
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		chk("rdata", e, rdata);
		chk("rresp", 32'(er), 32'(rresp));
	endtask : rdc
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// Main sequence
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i])
			rdc(rows[i].a, rows[i].d, rows[i].r);
		wr(8'hf0, 32'hffff_ffff, RESP_SLVERR);
		// Pin master clock, ring off, then APLL-only
		wr(OFF_MCR, 32'h1);
		chk("from_ext", 32'h1, 32'(master_clk_from_ext));
		wr(OFF_MCR, 32'h3);
		chk("ring_osc_en", 32'h0, 32'(ring_osc_en));
		wr(OFF_MCR, 32'h7);
		chk("ring_osc_en", 32'h1, 32'(ring_osc_en));
		chk("reg_clk", 32'h1, 32'(reg_clk_from_ring));
		wr(OFF_MCR, 32'h0);
		// Input 0 at 5 MHz gives 32 edges in each 256-cycle window
		wr(OFF_ACTWIN, 32'h40);
		wr(OFF_FRQWIN, 32'hff);
		wr(OFF_QUAL, 32'h40);
		wr(8'h60, 32'h20);
		wr(OFF_IEN, 32'h1);
		run <= 3'h1;
		repeat (1200) @(posedge aclk);
		rdc(8'h30, 32'h37);
		rdc(OFF_VAL, 32'h101);
		wr(OFF_VAL, 32'h100);
		rdc(OFF_VAL, 32'h1);
		wr(OFF_MQC, 32'h6);
		chk("selectable", 32'h0, 32'(ref_selectable));
		chk("valid", 32'h1, 32'(ref_valid));
		wr(OFF_MQC, 32'h7);
		// Edge choice and divider seen as edge counts
		foreach (icr[i]) begin
			wr(8'h40, 32'(icr[i]));
			repeat (16) @(posedge aclk);
			e0 = edges;
			repeat (256) @(posedge aclk);
			chk("edges", 32 / (32'(icr[i][7:4]) + 1), 32'(edges - e0));
		end
		// A quarter of the rate: only activity still passes
		repeat (600) @(posedge aclk);
		rdc(8'h30, 32'h01);
		chk("valid", 32'h0, 32'(ref_valid));
		// Active-low loss on GPIO1 overrides every monitor
		wr(8'h40, 32'h0);
		wr(OFF_GPIO, 32'h1);
		wr(8'h50, 32'h0064_0a27);
		gpio_pin <= 3'h6;
		repeat (600) @(posedge aclk);
		rdc(8'h30, 32'h08);
		gpio_pin <= 3'h7;
		repeat (1200) @(posedge aclk);
		rdc(8'h30, 32'h37);
		// Reference stopped, monitors enabled one at a time
		run <= 3'h0;
		foreach (mon[i]) begin
			wr(8'h50, {24'h0064_0a, mon[i]});
			repeat (600) @(posedge aclk);
			rdc(8'h30, 32'(isr[i]));
		end
		gpio_pin <= 3'h6;
		repeat (20) @(posedge aclk);
		rdc(8'h30, 32'h0f);
		gpio_pin <= 3'h7;
		// Selected input stays unlocked past the timeout
		wr(OFF_LOCK_TIMEOUT_FLAG, 32'h20);
		selected_ref <= 2'h0;
		dpll_locked <= 1'b0;
		repeat (100) @(posedge aclk);
		rdc(8'h30, 32'h77);
		chk("valid", 32'h0, 32'(ref_valid));
		dpll_locked <= 1'b1;
		wr(8'h30, 32'h40);
		rdc(8'h30, 32'h37);
		// Input switched off: no edges, no pass or usable, disabled monitors still read ok
		wr(OFF_IEN, 32'h0);
		run <= 3'h1;
		e0 = edges;
		repeat (100) @(posedge aclk);
		chk("edges", 32'h0, 32'(edges - e0));
		rdc(8'h30, 32'h07);
		finish_test();
	end
endmodule : test_input_clock_monitor_validation
`default_nettype wire
